// ### shared/membus_pkg.sv
// Shared constants and carriers for the DDR memory bus host controller.
// Assumes one core clock; the bus clock is made by dividing it.
package membus_pkg;

	localparam int CMD_RW_BIT    = 47;
	localparam int CMD_SPACE_BIT = 46;
	localparam int CMD_BURST_BIT = 45;
	localparam int CMD_ROW_HI    = 44;
	localparam int CMD_ROW_LO    = 16;
	localparam int CMD_COL_HI    = 2;
	localparam int CMD_COL_LO    = 0;
	localparam int CMD_BYTES     = 6;
	localparam int CMD_WIDTH     = 48;
	localparam int ADDR_WIDTH    = 32;

	localparam int   LATENCY_DEFAULT  = 6;
	localparam int   CLK_HALF_DEFAULT = 2;
	localparam int   CS_HIGH_NS       = 10;
	localparam int   CORE_PERIOD_NS   = 25;
	localparam int   CS_HIGH_CYCLES   = (CS_HIGH_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
	localparam int   PORST_SYNC_STAGES = 2;

	typedef struct packed {
		logic                  read;
		logic                  reg_space;
		logic                  linear;
		logic [ADDR_WIDTH-1:0] word_addr;
		logic [7:0]            words;
		logic                  zero_latency;
	} request_s;

	typedef struct packed {
		logic [7:0] data;
		logic       oe;
	} byte_drive_s;

endpackage

// ### rtl/membus_clk_div.sv
// Bus clock divider: makes one-cycle edge enables for the bus clock.
// Assumes the core clock domain; runs only while enabled.
`timescale 1ns/1ps
module membus_clk_div #(
	parameter int HALF = 2
) (
	input  wire logic clk_in,
	input  wire logic rst_in,
	input  wire logic run_in,
	output logic      tick_out
);

	logic [7:0] count;

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			count    <= 8'h00;
			tick_out <= 1'b0;
		end else if (!run_in) begin
			count    <= 8'h00;
			tick_out <= 1'b0;
		end else if (count == 8'(HALF - 1)) begin
			count    <= 8'h00;
			tick_out <= 1'b1;
		end else begin
			count    <= count + 8'h01;
			tick_out <= 1'b0;
		end
	end

endmodule

// ### rtl/membus_host.sv
// Host controller for a pseudo-static RAM on an eight-bit DDR memory bus.
// Assumes bus pins are registered in this core domain; bus clock is divided down.
`timescale 1ns/1ps
module membus_host #(
	parameter int LATENCY  = membus_pkg::LATENCY_DEFAULT,
	parameter int CLK_HALF = membus_pkg::CLK_HALF_DEFAULT
) (
	input  wire logic                 CORE_CLK_IN,
	input  wire logic                 RST_IN,
	input  wire membus_pkg::request_s REQ_IN,
	input  wire logic                 REQ_VALID_IN,
	output logic                      REQ_READY_OUT,
	input  wire logic [15:0]          WDATA_IN,
	input  wire logic [1:0]           WMASK_IN,
	output logic                      WDATA_TAKE_OUT,
	output logic [15:0]               RDATA_OUT,
	output logic                      RDATA_VALID_OUT,
	output logic                      DONE_OUT,
	output logic                      IRQ_OUT,
	output logic                      SLAVE_READY_OUT,
	output logic                      CHIP_SEL_N_OUT,
	output logic                      BUS_CLK_OUT,
	output logic                      BUS_CLK_COMP_OUT,
	output logic [7:0]                IO_LINES_OUT,
	output logic                      IO_LINES_OE_OUT,
	input  wire logic [7:0]           IO_LINES_IN,
	output logic                      STROBE_MASK_OUT,
	output logic                      STROBE_MASK_OE_OUT,
	input  wire logic                 STROBE_MASK_IN,
	output logic                      HW_RESET_N_OUT,
	input  wire logic                 POR_STATUS_N_IN,
	input  wire logic                 EVENT_IRQ_N_IN
);

	typedef enum logic [5:0] {
		S_IDLE  = 6'b000001,
		S_CMD   = 6'b000010,
		S_WAIT  = 6'b000100,
		S_DATA  = 6'b001000,
		S_END   = 6'b010000,
		S_GAP   = 6'b100000
	} state_e;

	state_e                           state;
	membus_pkg::request_s             req;
	logic [membus_pkg::CMD_WIDTH-1:0] cmd;
	logic [7:0]                       edge_count;
	logic [7:0]                       words_left;
	logic                             extra_latency;
	logic                             tick;
	logic                             run;
	logic [15:0]                      read_word;
	logic [7:0]                       gap_count;
	logic [2:0]                       rd_mark;
	logic [2:0]                       rd_phase;
	logic [7:0]                       io_s1;
	logic [7:0]                       io_s2;
	logic                             strobe_mask_line_s1;
	logic                             strobe_mask_line_s2;
	logic                             por_s1;
	logic                             por_s2;
	logic                             irq_s1;
	logic                             irq_s2;

	////////////////////////////////////////////////////////////////////////////////
	// Input synchronisers
	always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			io_s1   <= 8'h00;
			io_s2   <= 8'h00;
			strobe_mask_line_s1 <= 1'b0;
			strobe_mask_line_s2 <= 1'b0;
			por_s1  <= 1'b0;
			por_s2  <= 1'b0;
			irq_s1  <= 1'b1;
			irq_s2  <= 1'b1;
		end else begin
			io_s1   <= IO_LINES_IN;
			io_s2   <= io_s1;
			strobe_mask_line_s1 <= STROBE_MASK_IN;
			strobe_mask_line_s2 <= strobe_mask_line_s1;
			por_s1  <= POR_STATUS_N_IN;
			por_s2  <= por_s1;
			irq_s1  <= EVENT_IRQ_N_IN;
			irq_s2  <= irq_s1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read capture, delayed to match the pin synchronisers
	always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			rd_mark         <= 3'h0;
			rd_phase        <= 3'h0;
			read_word       <= 16'h0000;
			RDATA_OUT       <= 16'h0000;
			RDATA_VALID_OUT <= 1'b0;
		end else begin
			rd_mark         <= {rd_mark[1:0], (state == S_DATA) && tick && req.read};
			rd_phase        <= {rd_phase[1:0], BUS_CLK_OUT};
			RDATA_VALID_OUT <= 1'b0;
			if (rd_mark[2] && !rd_phase[2]) begin
				read_word[15:8] <= io_s2;
			end
			if (rd_mark[2] && rd_phase[2]) begin
				RDATA_OUT       <= {read_word[15:8], io_s2};
				RDATA_VALID_OUT <= 1'b1;
			end
		end
	end

	always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			SLAVE_READY_OUT <= 1'b0;
			IRQ_OUT         <= 1'b0;
			HW_RESET_N_OUT  <= 1'b0;
		end else begin
			SLAVE_READY_OUT <= por_s2;
			IRQ_OUT         <= !irq_s2;
			HW_RESET_N_OUT  <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Bus clock edge enables
	assign run = (state == S_CMD) || (state == S_WAIT) || (state == S_DATA);

	membus_clk_div #(
		.HALF(CLK_HALF)
	) u_div (
		.clk_in  (CORE_CLK_IN),
		.rst_in  (RST_IN),
		.run_in  (run),
		.tick_out(tick)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Transaction sequencer
	always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			state              <= S_IDLE;
			req                <= '0;
			cmd                <= '0;
			edge_count         <= 8'h00;
			words_left         <= 8'h00;
			extra_latency      <= 1'b0;
			gap_count          <= 8'h00;
			REQ_READY_OUT      <= 1'b0;
			CHIP_SEL_N_OUT     <= 1'b1;
			BUS_CLK_OUT        <= 1'b0;
			BUS_CLK_COMP_OUT   <= 1'b1;
			IO_LINES_OUT       <= 8'h00;
			IO_LINES_OE_OUT    <= 1'b0;
			STROBE_MASK_OUT    <= 1'b0;
			STROBE_MASK_OE_OUT <= 1'b0;
			WDATA_TAKE_OUT     <= 1'b0;
			DONE_OUT           <= 1'b0;
		end else begin
			WDATA_TAKE_OUT  <= 1'b0;
			REQ_READY_OUT   <= 1'b0;
			DONE_OUT        <= 1'b0;
			unique case (state)
				S_IDLE: begin
					if (REQ_VALID_IN && REQ_READY_OUT) begin
						req <= REQ_IN;
						cmd <= {REQ_IN.read, REQ_IN.reg_space, REQ_IN.linear,
							REQ_IN.word_addr[31:3], 13'h0000, REQ_IN.word_addr[2:0]};
						CHIP_SEL_N_OUT  <= 1'b0;
						edge_count      <= 8'h00;
						words_left      <= REQ_IN.words;
						IO_LINES_OE_OUT <= 1'b1;
						IO_LINES_OUT    <= {REQ_IN.read, REQ_IN.reg_space, REQ_IN.linear,
							REQ_IN.word_addr[31:27]};
						state           <= S_CMD;
					end else begin
						REQ_READY_OUT <= SLAVE_READY_OUT;
					end
				end
				S_CMD: begin
					if (tick) begin
						BUS_CLK_OUT      <= !BUS_CLK_OUT;
						BUS_CLK_COMP_OUT <= BUS_CLK_OUT;
						if (edge_count == 8'h00) begin
							extra_latency <= strobe_mask_line_s2;
						end
						edge_count <= edge_count + 8'h01;
						if (edge_count == 8'(membus_pkg::CMD_BYTES - 1)) begin
							edge_count <= 8'h00;
							if (!req.read && req.zero_latency) begin
								IO_LINES_OUT <= WDATA_IN[15:8];
								state <= S_DATA;
							end else begin
								IO_LINES_OE_OUT <= 1'b0;
								state <= S_WAIT;
							end
						end else begin
							IO_LINES_OUT <= 8'(cmd >> (8 * (membus_pkg::CMD_BYTES - 2
								- int'(edge_count))));
						end
					end
				end
				S_WAIT: begin
					if (tick) begin
						BUS_CLK_OUT      <= !BUS_CLK_OUT;
						BUS_CLK_COMP_OUT <= BUS_CLK_OUT;
						edge_count <= edge_count + 8'h01;
						if (edge_count == 8'((extra_latency ? 4 : 2) * LATENCY - 1)) begin
							edge_count <= 8'h00;
							if (!req.read) begin
								IO_LINES_OE_OUT    <= 1'b1;
								IO_LINES_OUT       <= WDATA_IN[15:8];
								STROBE_MASK_OE_OUT <= 1'b1;
								STROBE_MASK_OUT    <= WMASK_IN[1];
							end
							state <= S_DATA;
						end
					end
				end
				S_DATA: begin
					if (tick) begin
						BUS_CLK_OUT      <= !BUS_CLK_OUT;
						BUS_CLK_COMP_OUT <= BUS_CLK_OUT;
						if (!req.read && !BUS_CLK_OUT) begin
							IO_LINES_OUT <= WDATA_IN[7:0];
							STROBE_MASK_OUT <= req.zero_latency ? 1'b0 : WMASK_IN[0];
							WDATA_TAKE_OUT <= 1'b1;
						end
						if (BUS_CLK_OUT) begin
							words_left <= words_left - 8'h01;
							if (words_left == 8'h01) begin
								state <= S_END;
							end else if (!req.read) begin
								IO_LINES_OUT    <= WDATA_IN[15:8];
								STROBE_MASK_OUT <= req.zero_latency ? 1'b0 : WMASK_IN[1];
							end
						end
					end
				end
				S_END: begin
					CHIP_SEL_N_OUT     <= 1'b1;
					IO_LINES_OE_OUT    <= 1'b0;
					STROBE_MASK_OE_OUT <= 1'b0;
					gap_count          <= 8'h00;
					DONE_OUT           <= 1'b1;
					state              <= S_GAP;
				end
				S_GAP: begin
					gap_count <= gap_count + 8'h01;
					if (gap_count >= 8'(membus_pkg::CS_HIGH_CYCLES)) begin
						state <= S_IDLE;
					end
				end
				default: begin
					state <= S_IDLE;
				end
			endcase
		end
	end

endmodule

// ### sim/membus_host_checker.sv
// Assertion checker on the memory bus host top ports.
// Assumes bind to the host; one core clock domain.
`timescale 1ns/1ps
module membus_host_checker (
	input  wire logic CORE_CLK_IN,
	input  wire logic RST_IN,
	input  wire logic CHIP_SEL_N_OUT,
	input  wire logic BUS_CLK_OUT,
	input  wire logic BUS_CLK_COMP_OUT,
	input  wire logic STROBE_MASK_OE_OUT,
	input  wire logic IO_LINES_OE_OUT,
	input  wire logic HW_RESET_N_OUT,
	input  wire logic EVENT_IRQ_N_IN,
	input  wire logic IRQ_OUT,
	input  wire logic DONE_OUT,
	input  wire logic REQ_READY_OUT,
	input  wire logic SLAVE_READY_OUT
);
	default clocking cb @(posedge CORE_CLK_IN);
	endclocking
	default disable iff (RST_IN);
	sequence cs_open;
		$fell(CHIP_SEL_N_OUT);
	endsequence
	sequence cs_close;
		$rose(CHIP_SEL_N_OUT);
	endsequence
	////////////////////////////////////////
	a_cs_fall_idle: assert property (cs_open |-> !BUS_CLK_OUT && BUS_CLK_COMP_OUT)
		else $error("select fell with clock busy");
	a_cs_rise_idle: assert property (cs_close |-> !BUS_CLK_OUT)
		else $error("select rose with clock high");
	a_clk_stop_idle: assert property (CHIP_SEL_N_OUT |-> !BUS_CLK_OUT)
		else $error("clock runs while deselected");
	a_ca_no_mask: assert property (cs_open |-> !STROBE_MASK_OE_OUT [*8])
		else $error("host drove strobe in command phase");
	a_mask_with_data: assert property (STROBE_MASK_OE_OUT |-> IO_LINES_OE_OUT)
		else $error("mask driven without write data");
	a_hw_reset_rel: assert property ($fell(RST_IN) |=> HW_RESET_N_OUT)
		else $error("slave reset not released");
	a_irq_follow: assert property ($fell(EVENT_IRQ_N_IN) |-> ##[2:4] IRQ_OUT)
		else $error("interrupt flag late");
	a_done_on_close: assert property (cs_close |-> ##[0:2] DONE_OUT)
		else $error("no done after select rose");
	a_ready_gated: assert property (REQ_READY_OUT |-> SLAVE_READY_OUT)
		else $error("ready before slave ready");
endmodule
bind membus_host membus_host_checker i_membus_host_checker (
	.CORE_CLK_IN(CORE_CLK_IN), .RST_IN(RST_IN), .CHIP_SEL_N_OUT(CHIP_SEL_N_OUT),
	.BUS_CLK_OUT(BUS_CLK_OUT), .BUS_CLK_COMP_OUT(BUS_CLK_COMP_OUT),
	.STROBE_MASK_OE_OUT(STROBE_MASK_OE_OUT), .IO_LINES_OE_OUT(IO_LINES_OE_OUT),
	.HW_RESET_N_OUT(HW_RESET_N_OUT), .EVENT_IRQ_N_IN(EVENT_IRQ_N_IN), .IRQ_OUT(IRQ_OUT),
	.DONE_OUT(DONE_OUT), .REQ_READY_OUT(REQ_READY_OUT), .SLAVE_READY_OUT(SLAVE_READY_OUT)
);

// ### sim/membus_slave_model.sv
// Behavioural slave memory on the DDR bus.
// Assumes the bench resolves shared pins from both enables.
`timescale 1ns/1ps
module membus_slave_model #(
	parameter int LAT    = 2,
	parameter int POR_NS = 1000
) (
	input  wire logic       bus_clk_in,
	input  wire logic       chip_sel_n_in,
	input  wire logic       hw_reset_n_in,
	input  wire logic [7:0] io_in,
	input  wire logic       strobe_in,
	input  wire logic       extra_in,
	input  wire logic       zero_lat_in,
	input  wire logic       irq_in,
	output logic [7:0]      io_out,
	output logic            io_oe_out,
	output logic            strobe_out,
	output logic            strobe_oe_out,
	output logic            por_drive_out,
	output logic            irq_drive_out
);
	logic [47:0] ca;
	logic [15:0] mem [16];
	logic        xtra;
	logic [3:0]  w;
	int          n;
	int          d;
	assign irq_drive_out = irq_in;
	initial begin
		io_oe_out = 1'b0;
		strobe_oe_out = 1'b0;
		n = 0;
		por_drive_out = 1'b1;
		#(POR_NS);
		por_drive_out = 1'b0;
	end
	////////////////////////////////////////
	always @(negedge chip_sel_n_in) begin
		n = 0;
		xtra = extra_in;
		strobe_out = extra_in;
		strobe_oe_out = hw_reset_n_in;
	end
	always @(posedge chip_sel_n_in or negedge hw_reset_n_in) begin
		io_oe_out = 1'b0;
		strobe_oe_out = 1'b0;
		n = 0;
	end
	always @(bus_clk_in) if (!chip_sel_n_in && hw_reset_n_in) begin
		d = n - 6 - (zero_lat_in ? 0 : (xtra ? 4 : 2) * LAT);
		w = {ca[16], ca[2:0]} + 4'(d / 2);
		if (n < 6) ca = {ca[39:0], io_in};
		else if (ca[47] && d >= 0) begin
			io_out = bus_clk_in ? mem[w][15:8] : mem[w][7:0];
			io_oe_out = 1'b1;
			strobe_out = bus_clk_in;
		end else if (ca[47]) strobe_out = 1'b0;
		else if (d >= 0 && (zero_lat_in || !strobe_in)) begin
			if (bus_clk_in) mem[w][15:8] = io_in;
			else mem[w][7:0] = io_in;
		end
		if (n == 5 && !ca[47]) strobe_oe_out = 1'b0;
		n = n + 1;
	end
endmodule

// ### sim/testbench.sv
// Self-checking bench for the memory bus host.
// Assumes the slave model and bound checker.
`timescale 1ns/1ps
module testbench;
	localparam int LAT = 2;
	logic                 clk = 1'b0;
	logic                 rst = 1'b1;
	logic                 vld = 1'b0;
	logic                 xt = 1'b0;
	logic                 zl = 1'b0;
	logic                 irq = 1'b0;
	logic                 flip = 1'b0;
	logic                 sm_seen = 1'b0;
	membus_pkg::request_s req = '0;
	logic [15:0]          wd [4];
	logic [1:0]           wm [4];
	logic [15:0]          rq [4];
	logic [15:0]          rdata;
	logic [7:0]           h_io, m_io, io_w;
	logic                 rdy, take, rvld, done, irq_o, sready, cs_n, bclk, hw_n;
	logic                 h_oe, m_oe, h_sm, m_sm, h_smoe, m_smoe, sm_w, m_por, m_irq;
	int                   wi = 0;
	int                   ri = 0;
	int                   err_total = 0;
	int                   samples_checked = 0;
	assign io_w = h_oe ? h_io : (m_oe ? m_io : {8{flip}});
	assign sm_w = h_smoe ? h_sm : (m_smoe ? m_sm : flip);
	// Slave sees pins after its hold time
	logic [7:0]           io_d;
	logic                 sm_d;
	assign #1 io_d = io_w;
	assign #1 sm_d = sm_w;
	always #12.5 clk = ~clk;
	always @(posedge clk) flip <= ~flip;
	always @(negedge clk) begin
		if (take) wi++;
		if (rvld) rq[ri[1:0]] = rdata;
		if (rvld) ri++;
		if (h_smoe) sm_seen = 1'b1;
	end
	membus_host #(.LATENCY(LAT), .CLK_HALF(2)) i_membus_host (
		.CORE_CLK_IN(clk), .RST_IN(rst), .REQ_IN(req), .REQ_VALID_IN(vld),
		.REQ_READY_OUT(rdy), .WDATA_IN(wd[wi[1:0]]), .WMASK_IN(wm[wi[1:0]]),
		.WDATA_TAKE_OUT(take), .RDATA_OUT(rdata), .RDATA_VALID_OUT(rvld), .DONE_OUT(done),
		.IRQ_OUT(irq_o), .SLAVE_READY_OUT(sready), .CHIP_SEL_N_OUT(cs_n), .BUS_CLK_OUT(bclk),
		.BUS_CLK_COMP_OUT(), .IO_LINES_OUT(h_io), .IO_LINES_OE_OUT(h_oe), .IO_LINES_IN(io_w),
		.STROBE_MASK_OUT(h_sm), .STROBE_MASK_OE_OUT(h_smoe), .STROBE_MASK_IN(sm_w),
		.HW_RESET_N_OUT(hw_n), .POR_STATUS_N_IN(!m_por), .EVENT_IRQ_N_IN(!m_irq));
	membus_slave_model #(.LAT(LAT)) i_membus_slave_model (
		.bus_clk_in(bclk), .chip_sel_n_in(cs_n), .hw_reset_n_in(hw_n), .io_in(io_d),
		.strobe_in(sm_d), .extra_in(xt), .zero_lat_in(zl), .irq_in(irq), .io_out(m_io),
		.io_oe_out(m_oe), .strobe_out(m_sm), .strobe_oe_out(m_smoe),
		.por_drive_out(m_por), .irq_drive_out(m_irq));
	////////////////////////////////////////
	task automatic check(input string s, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic run(input logic rd, rs, lin, z, x, input logic [31:0] a, input logic [7:0] nw);
		int k;
		wi = 0;
		ri = 0;
		xt = x;
		zl = z;
		req = '{rd, rs, lin, a, nw, z};
		vld = 1'b1;
		k = 0;
		while (rdy !== 1'b1 && k < 400) begin
			@(negedge clk);
			k++;
		end
		@(negedge clk);
		vld = 1'b0;
		while (done !== 1'b1 && k < 4000) begin
			@(negedge clk);
			k++;
		end
		check("done", 1, done);
		repeat (4) @(negedge clk);
	endtask
	task automatic t_write();
		wd = '{16'h1234, 16'habcd, 16'h0, 16'h0};
		wm = '{2'h0, 2'h2, 2'h0, 2'h0};
		i_membus_slave_model.mem[5] = 16'h5566;
		run(1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 32'h4, 8'h2);
		check("word0", 16'h1234, i_membus_slave_model.mem[4]);
		check("word1", 16'h55cd, i_membus_slave_model.mem[5]);
		check("cmd", 16'h1, i_membus_slave_model.ca[47:45]);
		check("col", 16'h4, i_membus_slave_model.ca[2:0]);
		$display("test write done");
	endtask
	task automatic t_read();
		run(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 32'h4, 8'h2);
		check("rd0", 16'h1234, rq[0]);
		check("rd1", 16'h55cd, rq[1]);
		check("count", 16'h2, 16'(ri));
		check("cmd", 16'h4, i_membus_slave_model.ca[47:45]);
		$display("test read done");
	endtask
	task automatic t_zero();
		wd[0] = 16'h9a7c;
		wm[0] = 2'h3;
		sm_seen = 1'b0;
		run(1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 32'h1, 8'h1);
		check("zl word", 16'h9a7c, i_membus_slave_model.mem[1]);
		check("zl strobe", 16'h0, sm_seen);
		check("space", 16'h1, i_membus_slave_model.ca[46]);
		$display("test zero latency done");
	endtask
	task automatic t_irq_rst();
		irq = 1'b1;
		repeat (5) @(negedge clk);
		check("irq", 1, irq_o);
		irq = 1'b0;
		rst = 1'b1;
		repeat (5) @(negedge clk);
		check("irq off", 0, irq_o);
		check("pins", 16'h1, {hw_n, cs_n});
		rst = 1'b0;
		repeat (3) @(negedge clk);
		check("hw rel", 1, hw_n);
		$display("test irq reset done");
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		#300000;
		err_total++;
		report_and_stop();
	end
	initial begin
		wd = '{default: '0};
		wm = '{default: '0};
		repeat (16) @(negedge clk);
		rst = 1'b0;
		check("por", 16'h0, {rdy, sready});
		t_write();
		t_read();
		t_zero();
		t_irq_rst();
		t_read();
		report_and_stop();
	end
endmodule
